// File: hdl/sfsp_pkg.sv
`default_nettype none
// ****************************************************************
// Register map and field layout
// ****************************************************************
package sfsp_pkg;
   localparam logic [7:0] SFSP_STACK_POINTER_ADDR = 8'h81;
   localparam logic [7:0] SFSP_STATUS_WORD_ADDR = 8'hD0;
   localparam logic [7:0] SFSP_MAIN_OPERAND_ADDR = 8'hE0;
   localparam logic [7:0] SFSP_SECOND_OPERAND_ADDR = 8'hF0;
   localparam logic [7:0] SFSP_STACK_POINTER_RESET = 8'h07;
   localparam logic [7:0] SFSP_STATUS_WORD_RESET = 8'h00;
   localparam logic [7:0] SFSP_MAIN_OPERAND_RESET = 8'h00;
   localparam logic [7:0] SFSP_SECOND_OPERAND_RESET = 8'h00;
   localparam int SFSP_CARRY_BIT = 7;
   localparam int SFSP_NIBBLE_BIT = 6;
   localparam int SFSP_USER0_BIT = 5;
   localparam int SFSP_BANK_HI_BIT = 4;
   localparam int SFSP_BANK_LO_BIT = 3;
   localparam int SFSP_RANGE_BIT = 2;
   localparam int SFSP_USER1_BIT = 1;
   localparam int SFSP_PARITY_BIT = 0;
   localparam logic [7:0] SFSP_BANK_BYTES = 8'h08;
   typedef enum logic [2:0] {
      SFSP_OP_NONE, SFSP_OP_ADD, SFSP_OP_ADDC, SFSP_OP_SUBB, SFSP_OP_MUL, SFSP_OP_DIV
   } sfsp_op_t;
   typedef enum logic [1:0] {SFSP_STK_IDLE, SFSP_STK_PUSH, SFSP_STK_POP} sfsp_stk_t;
endpackage
`default_nettype wire

// File: hdl/sfsp_status_stack.sv
`default_nettype none
module sfsp_status_stack
   import sfsp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   output logic sfr_hit_out,
   input wire sfsp_op_t op_in,
   input wire logic [7:0] op_a_in,
   input wire logic [7:0] op_b_in,
   input wire logic main_load_in,
   input wire logic [7:0] main_value_in,
   input wire logic second_load_in,
   input wire logic [7:0] second_value_in,
   input wire sfsp_stk_t stack_op_in,
   output logic [7:0] stack_addr_out,
   output logic stack_wr_out,
   output logic stack_rd_out,
   input wire logic [2:0] reg_index_in,
   output logic [7:0] reg_addr_out,
   output logic [7:0] stack_pointer_out,
   output logic [7:0] status_word_out,
   output logic [7:0] main_operand_out
);
   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [7:0] stack_pointer;
   logic [7:0] status_word_reg;
   logic [7:0] main_operand_reg;
   logic [7:0] second_operand_reg;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [15:0] product;
   logic carry_in;
   logic next_carry, next_nibble, next_range;
   logic arith;
   logic parity;
   logic [7:0] status_view;
   logic [7:0] next_stack_pointer;
   logic [7:0] stack_push_addr;

   assign carry_in = (op_in == SFSP_OP_ADD) ? 1'b0 : status_word_reg[SFSP_CARRY_BIT];
   assign product = op_a_in * op_b_in;
   assign parity = ^main_operand_reg;
   assign status_view = {status_word_reg[7:1], parity};
   assign stack_push_addr = stack_pointer + 8'h01;

   // ****************************************************************
   // Flag arithmetic
   // ****************************************************************
   always_comb begin
      sum9 = 9'h000;
      sum5 = 5'h00;
      next_carry = status_word_reg[SFSP_CARRY_BIT];
      next_nibble = status_word_reg[SFSP_NIBBLE_BIT];
      next_range = status_word_reg[SFSP_RANGE_BIT];
      arith = 1'b1;
      case (op_in)
         SFSP_OP_ADD, SFSP_OP_ADDC: begin
            sum9 = {1'b0, op_a_in} + {1'b0, op_b_in} + {8'h00, carry_in};
            sum5 = {1'b0, op_a_in[3:0]} + {1'b0, op_b_in[3:0]} + {4'h0, carry_in};
            next_carry = sum9[8];
            next_nibble = sum5[4];
            next_range = (op_a_in[7] == op_b_in[7]) && (sum9[7] != op_a_in[7]);
         end
         SFSP_OP_SUBB: begin
            sum9 = {1'b0, op_a_in} - {1'b0, op_b_in} - {8'h00, carry_in};
            sum5 = {1'b0, op_a_in[3:0]} - {1'b0, op_b_in[3:0]} - {4'h0, carry_in};
            next_carry = sum9[8];
            next_nibble = sum5[4];
            next_range = (op_a_in[7] != op_b_in[7]) && (sum9[7] != op_a_in[7]);
         end
         SFSP_OP_MUL: begin
            next_carry = 1'b0;
            next_range = (product[15:8] != 8'h00);
         end
         SFSP_OP_DIV: begin
            next_carry = 1'b0;
            next_range = (op_b_in == 8'h00);
         end
         default: arith = 1'b0;
      endcase
   end

   // ****************************************************************
   // Status word; parity bit is never stored, it is live from the accumulator
   // ****************************************************************
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         status_word_reg <= SFSP_STATUS_WORD_RESET;
      end else if (sfr_wr_in && sfr_addr_in == SFSP_STATUS_WORD_ADDR) begin
         status_word_reg <= {sfr_wdata_in[7:1], 1'b0};
      end else if (arith) begin
         // User flags and bank select untouched by arithmetic
         status_word_reg[SFSP_CARRY_BIT] <= next_carry;
         status_word_reg[SFSP_NIBBLE_BIT] <= next_nibble;
         status_word_reg[SFSP_RANGE_BIT] <= next_range;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         main_operand_reg <= SFSP_MAIN_OPERAND_RESET;
      end else if (sfr_wr_in && sfr_addr_in == SFSP_MAIN_OPERAND_ADDR) begin
         main_operand_reg <= sfr_wdata_in;
      end else if (main_load_in) begin
         main_operand_reg <= main_value_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         second_operand_reg <= SFSP_SECOND_OPERAND_RESET;
      end else if (sfr_wr_in && sfr_addr_in == SFSP_SECOND_OPERAND_ADDR) begin
         second_operand_reg <= sfr_wdata_in;
      end else if (second_load_in) begin
         second_operand_reg <= second_value_in;
      end
   end

   // ****************************************************************
   // Stack pointer; wraps mod 256 so any byte of data memory is reachable
   // ****************************************************************
   always_comb begin
      next_stack_pointer = stack_pointer;
      if (sfr_wr_in && sfr_addr_in == SFSP_STACK_POINTER_ADDR) begin
         next_stack_pointer = sfr_wdata_in;
      end else if (stack_op_in == SFSP_STK_PUSH) begin
         next_stack_pointer = stack_push_addr;
      end else if (stack_op_in == SFSP_STK_POP) begin
         next_stack_pointer = stack_pointer - 8'h01;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         stack_pointer <= SFSP_STACK_POINTER_RESET;
      end else begin
         stack_pointer <= next_stack_pointer;
      end
   end

   // Push writes at the incremented pointer, pop reads at the current one
   always_comb begin
      stack_wr_out = !reset_in && stack_op_in == SFSP_STK_PUSH;
      stack_rd_out = !reset_in && stack_op_in == SFSP_STK_POP;
      stack_addr_out = (stack_op_in == SFSP_STK_PUSH) ? stack_push_addr : stack_pointer;
   end

   // ****************************************************************
   // Working register bank address
   // ****************************************************************
   assign reg_addr_out = {3'b000, status_word_reg[SFSP_BANK_HI_BIT], status_word_reg[SFSP_BANK_LO_BIT],
      reg_index_in};

   // ****************************************************************
   // Register read
   // ****************************************************************
   always_comb begin
      sfr_hit_out = 1'b1;
      if (sfr_addr_in == SFSP_STACK_POINTER_ADDR) begin
         sfr_rdata_out = stack_pointer;
      end else if (sfr_addr_in == SFSP_STATUS_WORD_ADDR) begin
         sfr_rdata_out = status_view;
      end else if (sfr_addr_in == SFSP_MAIN_OPERAND_ADDR) begin
         sfr_rdata_out = main_operand_reg;
      end else if (sfr_addr_in == SFSP_SECOND_OPERAND_ADDR) begin
         sfr_rdata_out = second_operand_reg;
      end else begin
         sfr_rdata_out = 8'h00;
         sfr_hit_out = 1'b0;
      end
   end

   assign stack_pointer_out = stack_pointer;
   assign status_word_out = status_view;
   assign main_operand_out = main_operand_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_parity_live: assert property (@(posedge mclk_in) disable iff (reset_in)
      status_word_out[SFSP_PARITY_BIT] == ^main_operand_out) else $error("parity wrong");
   a_push_pre_inc: assert property (@(posedge mclk_in) disable iff (reset_in)
      (stack_op_in == SFSP_STK_PUSH && !sfr_wr_in) |-> stack_addr_out == stack_pointer + 8'h01 ##1
      stack_pointer == $past(stack_addr_out)) else $error("push not pre-incremented");
   a_pop_post_dec: assert property (@(posedge mclk_in) disable iff (reset_in)
      (stack_op_in == SFSP_STK_POP && !sfr_wr_in) |=> stack_pointer == $past(stack_addr_out) - 8'h01)
      else $error("pop not post-decremented");
   a_pointer_reset: assert property (@(posedge mclk_in) reset_in |=> stack_pointer == 8'h07)
      else $error("stack pointer reset wrong");
   a_status_reset: assert property (@(posedge mclk_in) reset_in |=> status_word_reg == 8'h00 &&
      main_operand_reg == 8'h00 && second_operand_reg == 8'h00) else $error("reset values wrong");
   a_mul_range: assert property (@(posedge mclk_in) disable iff (reset_in)
      (op_in == SFSP_OP_MUL && !sfr_wr_in) |=> status_word_reg[SFSP_RANGE_BIT] == ($past(product) > 16'd255))
      else $error("multiply overflow wrong");
   a_div_zero: assert property (@(posedge mclk_in) disable iff (reset_in)
      (op_in == SFSP_OP_DIV && !sfr_wr_in) |=> status_word_reg[SFSP_RANGE_BIT] == ($past(op_b_in) == 8'h00))
      else $error("divide overflow wrong");
   a_add_carry: assert property (@(posedge mclk_in) disable iff (reset_in)
      (op_in == SFSP_OP_ADD && !sfr_wr_in) |=> status_word_reg[SFSP_CARRY_BIT] ==
      (({1'b0, $past(op_a_in)} + {1'b0, $past(op_b_in)}) > 9'h0FF)) else $error("add carry wrong");
   a_user_keep: assert property (@(posedge mclk_in) disable iff (reset_in)
      (op_in != SFSP_OP_NONE && !sfr_wr_in) |=> $stable(status_word_reg[5:3]) && $stable(status_word_reg[1]))
      else $error("user bits changed");
   a_bank_map: assert property (@(posedge mclk_in) disable iff (reset_in)
      reg_addr_out < 8'h20 && reg_addr_out[7:3] == {3'b000, status_word_reg[4:3]})
      else $error("bank address wrong");
   c_push: cover property (@(posedge mclk_in) stack_op_in == SFSP_STK_PUSH);
   c_pop: cover property (@(posedge mclk_in) stack_op_in == SFSP_STK_POP);
   c_overflow: cover property (@(posedge mclk_in) op_in == SFSP_OP_ADD ##1 status_word_reg[SFSP_RANGE_BIT]);
endmodule
`default_nettype wire

// File: sim/tb.sv
`default_nettype none
module tb
   import sfsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_in, reset_in, sfr_wr_in, main_load_in, second_load_in, stack_wr_out, stack_rd_out, sfr_hit_out;
   logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, op_a_in, op_b_in, main_value_in, second_value_in;
   logic [7:0] stack_addr_out, reg_addr_out, stack_pointer_out, status_word_out, main_operand_out;
   logic [2:0] reg_index_in;
   sfsp_op_t op_in;
   sfsp_stk_t stack_op_in;
   int bad_count = 0;
   int checks = 0;
   sfsp_status_stack uut (.mclk_in(mclk_in), .reset_in(reset_in), .sfr_wr_in(sfr_wr_in),
      .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
      .sfr_hit_out(sfr_hit_out), .op_in(op_in), .op_a_in(op_a_in), .op_b_in(op_b_in),
      .main_load_in(main_load_in), .main_value_in(main_value_in), .second_load_in(second_load_in),
      .second_value_in(second_value_in),
      .stack_op_in(stack_op_in), .stack_addr_out(stack_addr_out), .stack_wr_out(stack_wr_out),
      .stack_rd_out(stack_rd_out), .reg_index_in(reg_index_in), .reg_addr_out(reg_addr_out),
      .stack_pointer_out(stack_pointer_out), .status_word_out(status_word_out),
      .main_operand_out(main_operand_out));
   // ****************************************************************
   // Shared driving and comparison
   // ****************************************************************
   task automatic complete_run;
      if (bad_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Inputs move 1 ns after the edge so the design never sees them change at sampling
   task automatic tick;
      @(posedge mclk_in);
      #1;
   endtask
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      tick();
      sfr_wr_in = 1'b0;
   endtask
   task automatic sfr_read(input string what, input logic [7:0] a, input logic [7:0] exp, input logic hit);
      sfr_addr_in = a;
      #1;
      chk(what, exp, sfr_rdata_out);
      chk("hit", {7'h00, hit}, {7'h00, sfr_hit_out});
   endtask
   // Flags compared as {carry, nibble, range} after one arithmetic step
   task automatic arith(input sfsp_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [2:0] exp);
      op_in = op;
      op_a_in = a;
      op_b_in = b;
      tick();
      op_in = SFSP_OP_NONE;
      chk("flags", {5'h00, exp}, {5'h00, status_word_out[SFSP_CARRY_BIT], status_word_out[SFSP_NIBBLE_BIT],
         status_word_out[SFSP_RANGE_BIT]});
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_reset;
      chk("pointer", SFSP_STACK_POINTER_RESET, stack_pointer_out);
      sfr_read("pointer read", SFSP_STACK_POINTER_ADDR, SFSP_STACK_POINTER_RESET, 1'b1);
      chk("status word", 8'h00, status_word_out);
      chk("main operand", 8'h00, main_operand_out);
      sfr_read("second operand", SFSP_SECOND_OPERAND_ADDR, 8'h00, 1'b1);
      sfr_read("unmapped", 8'h82, 8'h00, 1'b0);
   endtask
   task automatic test_stack;
      stack_op_in = SFSP_STK_PUSH;
      #1;
      chk("push addr", 8'h08, stack_addr_out);
      chk("push wr", 8'h01, {7'h00, stack_wr_out});
      tick();
      chk("pointer after push", 8'h08, stack_pointer_out);
      stack_op_in = SFSP_STK_POP;
      #1;
      chk("pop addr", 8'h08, stack_addr_out);
      chk("pop rd", 8'h01, {7'h00, stack_rd_out});
      tick();
      stack_op_in = SFSP_STK_IDLE;
      chk("pointer after pop", 8'h07, stack_pointer_out);
      sfr_write(SFSP_STACK_POINTER_ADDR, 8'hFF);
      stack_op_in = SFSP_STK_PUSH;
      #1;
      chk("wrap addr", 8'h00, stack_addr_out);
      tick();
      stack_op_in = SFSP_STK_IDLE;
      chk("pointer wrap", 8'h00, stack_pointer_out);
   endtask
   task automatic test_arith;
      sfr_write(SFSP_STATUS_WORD_ADDR, 8'h22);
      arith(SFSP_OP_ADD, 8'h7F, 8'h01, 3'b011);
      arith(SFSP_OP_ADD, 8'hFF, 8'h01, 3'b110);
      arith(SFSP_OP_SUBB, 8'h00, 8'h00, 3'b110);
      arith(SFSP_OP_ADDC, 8'h7F, 8'h00, 3'b011);
      arith(SFSP_OP_SUBB, 8'h80, 8'h01, 3'b011);
      arith(SFSP_OP_ADD, 8'h01, 8'h02, 3'b000);
      arith(SFSP_OP_MUL, 8'h10, 8'h10, 3'b001);
      arith(SFSP_OP_MUL, 8'h0F, 8'h11, 3'b000);
      arith(SFSP_OP_DIV, 8'h10, 8'h00, 3'b001);
      arith(SFSP_OP_DIV, 8'h10, 8'h02, 3'b000);
      chk("user flags", 8'h22, status_word_out & 8'h22);
   endtask
   task automatic test_banks;
      for (int i = 0; i < 4; i++) begin
         sfr_write(SFSP_STATUS_WORD_ADDR, 8'(i << SFSP_BANK_LO_BIT));
         reg_index_in = 3'h5;
         #1;
         chk("reg addr", 8'(i * 8 + 5), reg_addr_out);
      end
   endtask
   task automatic test_parity;
      logic [7:0] vals [4] = '{8'h01, 8'h03, 8'h7F, 8'hFF};
      for (int i = 0; i < 4; i++) begin
         main_value_in = vals[i];
         main_load_in = 1'b1;
         tick();
         main_load_in = 1'b0;
         chk("main operand", vals[i], main_operand_out);
         chk("parity", {7'h00, ^vals[i]}, {7'h00, status_word_out[SFSP_PARITY_BIT]});
      end
      second_value_in = 8'hA5;
      second_load_in = 1'b1;
      tick();
      second_load_in = 1'b0;
      sfr_read("second load", SFSP_SECOND_OPERAND_ADDR, 8'hA5, 1'b1);
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end
   initial begin
      reset_in = 1'b1;
      sfr_wr_in = 1'b0;
      sfr_addr_in = 8'h00;
      sfr_wdata_in = 8'h00;
      op_in = SFSP_OP_NONE;
      op_a_in = 8'h00;
      op_b_in = 8'h00;
      main_load_in = 1'b0;
      main_value_in = 8'h00;
      second_load_in = 1'b0;
      second_value_in = 8'h00;
      stack_op_in = SFSP_STK_IDLE;
      reg_index_in = 3'h0;
      repeat (12) tick();
      reset_in = 1'b0;
      test_reset();
      test_stack();
      test_arith();
      test_banks();
      test_parity();
      complete_run();
   end
endmodule
`default_nettype wire
